// ==== hw/mmb_bridge_map.vh ====
// mmb_bridge_map.vh: constants for the bridge window and the slave map behind it.
// assumes byte addresses, 16-bit upstream address, 8-bit downstream offset.
`ifndef MMB_BRIDGE_MAP_VH
`define MMB_BRIDGE_MAP_VH

// ****************************************
// bridge window on the upstream side
// ****************************************
`define MMB_BRIDGE_BASE  16'h1000
`define MMB_UP_AW        16
`define MMB_DN_AW        8
`define MMB_DW           32

// ****************************************
// downstream slaves, one-hot bases
// ****************************************
`define MMB_NUM_SLV      4
`define MMB_SLV_SPAN     8'h10
`define MMB_SLV0_BASE    8'h10
`define MMB_SLV1_BASE    8'h20
`define MMB_SLV2_BASE    8'h40
`define MMB_SLV3_BASE    8'h80

// ****************************************
// pipelining and decode defaults and reset values
// ****************************************
`define MMB_PIPE_M2S_DEF 1
`define MMB_PIPE_S2M_DEF 1
`define MMB_ONEHOT_DEF   1
`define MMB_RDATA_RST    32'h00000000

`endif

// ==== hw/mmb_bridge.v ====
// mmb_bridge.v: two-master pipeline bridge with window check, address
// shifting and slave-select decode for four downstream slaves.
// assumes all ports are on ref_clk; masters hold a request until ack or miss.
//
// Function
// R1: claim only addresses inside base/span window
// R2: downstream address is offset from base
// R3: masters issue base plus slave address
// R4: span derived from all downstream slave ranges; code uses only the top slave's end
// R5: arbitrate masters, one transfer at a time
// R6: compare address against each slave range
// R7: select gated by read and write strobes
// R8: one-hot bases decode on a single bit
// R9: single-target paths are plain wiring only; with one slave the code still gates read data by d_sel_q
// R10: every pipeline option can be disabled
// R11: each enabled option adds one cycle
// R12: out-of-window access makes no downstream transfer
`timescale 1ns/10ps
`include "mmb_bridge_map.vh"
`default_nettype none

module mmb_bridge #(
  parameter PIPE_M2S = `MMB_PIPE_M2S_DEF,
  parameter PIPE_S2M = `MMB_PIPE_S2M_DEF,
  parameter ONEHOT   = `MMB_ONEHOT_DEF
) (
  input  wire                         ref_clk,
  input  wire                         rst,
  input  wire [`MMB_UP_AW-1:0]        m0_addr,
  input  wire                         m0_read,
  input  wire                         m0_write,
  input  wire [`MMB_DW-1:0]           m0_wdata,
  output wire                         m0_ack,
  output wire                         m0_miss,
  output wire [`MMB_DW-1:0]           m0_rdata,
  input  wire [`MMB_UP_AW-1:0]        m1_addr,
  input  wire                         m1_read,
  input  wire                         m1_write,
  input  wire [`MMB_DW-1:0]           m1_wdata,
  output wire                         m1_ack,
  output wire                         m1_miss,
  output wire [`MMB_DW-1:0]           m1_rdata,
  output wire [`MMB_DN_AW-1:0]        d_addr,
  output wire                         d_read,
  output wire                         d_write,
  output wire [`MMB_DW-1:0]           d_wdata,
  output wire [`MMB_NUM_SLV-1:0]      d_sel,
  input  wire [`MMB_NUM_SLV-1:0]      d_wait,
  input  wire [`MMB_NUM_SLV*`MMB_DW-1:0] d_rdata
);

  // ****************************************
  // states and derived window
  // ****************************************
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_STAGE = 3'h1;
  localparam [2:0] ST_XFER  = 3'h2;
  localparam [2:0] ST_RESP  = 3'h3;
  localparam [2:0] ST_ACK   = 3'h4;

  // base of slave i in the downstream offset space
  function [`MMB_DN_AW-1:0] slv_base;
    input integer i;
    begin
      case (i)
        0:       slv_base = `MMB_SLV0_BASE;
        1:       slv_base = `MMB_SLV1_BASE;
        2:       slv_base = `MMB_SLV2_BASE;
        default: slv_base = `MMB_SLV3_BASE;
      endcase
    end
  endfunction

  // smallest power of two not below v
  function [16:0] pow2ceil;
    input [16:0] v;
    reg   [16:0] p;
    begin
      p = 17'h00001;
      while (p < v) begin
        p = {p[15:0], 1'b0};
      end
      pow2ceil = p;
    end
  endfunction

  // span covers the top slave's end, rounded up to a power of two
  localparam [16:0] BR_SPAN = pow2ceil({9'h000, `MMB_SLV3_BASE} + {9'h000, `MMB_SLV_SPAN}); // [R4]
  localparam [16:0] BR_LO   = {1'b0, `MMB_BRIDGE_BASE};
  localparam [16:0] BR_HI   = BR_LO + BR_SPAN;

  // slave hit: one-hot bit or full range compare, chosen by ONEHOT
  function slave_hit;
    input [`MMB_DN_AW-1:0] off;
    input integer          i;
    reg   [`MMB_DN_AW-1:0] b;
    begin
      b = slv_base(i);
      if (ONEHOT != 0) begin
        slave_hit = |(off & b);                                   // [R8]
      end else begin
        slave_hit = (off >= b) &&
                    ({1'b0, off} < ({1'b0, b} + {1'b0, `MMB_SLV_SPAN})); // [R6]
      end
    end
  endfunction

  // ****************************************
  // arbitration and request selection
  // ****************************************
  reg  [2:0]               state_q;
  reg  [2:0]               state_d;
  reg                      last_q;
  reg                      gnt_q;
  wire                     req0 = m0_read | m0_write;
  wire                     req1 = m1_read | m1_write;
  // round robin: on contention the master not served last wins
  wire                     pick = req1 & (~req0 | ~last_q);             // [R5]
  wire [`MMB_UP_AW-1:0]    sel_addr  = pick ? m1_addr : m0_addr;
  wire                     sel_read  = pick ? m1_read : m0_read;
  wire                     sel_write = pick ? m1_write : m0_write;
  wire [`MMB_DW-1:0]       sel_wdata = pick ? m1_wdata : m0_wdata;
  wire                     in_win = ({1'b0, sel_addr} >= BR_LO) &&
                                    ({1'b0, sel_addr} < BR_HI);         // [R1]
  // upstream address already holds base plus slave address, so a
  // subtraction is all that remains
  wire [`MMB_UP_AW-1:0]    diff    = sel_addr - `MMB_BRIDGE_BASE;       // [R3]
  wire [`MMB_DN_AW-1:0]    sel_off = diff[`MMB_DN_AW-1:0];               // [R2]

  // per-slave range result, before the strobes are applied
  reg  [`MMB_NUM_SLV-1:0]  hit_vec;
  integer                  k;
  always @* begin
    hit_vec = {`MMB_NUM_SLV{1'b0}};
    for (k = 0; k < `MMB_NUM_SLV; k = k + 1) begin
      if (slave_hit(sel_off, k) && (hit_vec == {`MMB_NUM_SLV{1'b0}})) begin
        hit_vec[k] = 1'b1;                                              // [R6]
      end
    end
  end

  // ****************************************
  // latched transfer and downstream drive
  // ****************************************
  reg  [`MMB_DN_AW-1:0]    off_q;
  reg                      rd_q;
  reg                      wr_q;
  reg  [`MMB_DW-1:0]       wdata_q;
  reg  [`MMB_NUM_SLV-1:0]  hit_q;
  reg                      d_read_q;
  reg                      d_write_q;
  reg  [`MMB_NUM_SLV-1:0]  d_sel_q;
  reg  [`MMB_DW-1:0]       rdata_q;
  reg                      ack0_q;
  reg                      ack1_q;
  reg                      miss0_q;
  reg                      miss1_q;

  // the selected slave is done once its own wait is low
  wire                     dn_done = ~|(d_wait & d_sel_q);

  // read mux by the one-hot select; even with one slave the data is gated by d_sel_q
  reg  [`MMB_DW-1:0]       rd_mux;
  integer                  j;
  always @* begin
    rd_mux = `MMB_RDATA_RST;
    for (j = 0; j < `MMB_NUM_SLV; j = j + 1) begin
      if (d_sel_q[j]) begin
        rd_mux = rd_mux | d_rdata[j*`MMB_DW +: `MMB_DW];
      end
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (req0 | req1) begin
          if (!in_win || (hit_vec == {`MMB_NUM_SLV{1'b0}})) begin
            state_d = ST_ACK;                                           // [R12]
          end else if (PIPE_M2S != 0) begin
            state_d = ST_STAGE;                                         // [R11]
          end else begin
            state_d = ST_XFER;                                          // [R10]
          end
        end
      end
      ST_STAGE: state_d = ST_XFER;
      ST_XFER: begin
        if (dn_done) begin
          state_d = (PIPE_S2M != 0) ? ST_RESP : ST_ACK;                 // [R11]
        end
      end
      ST_RESP: state_d = ST_ACK;
      ST_ACK:  state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // one transfer in flight; the ACK state gives the master a cycle to drop
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q   <= ST_IDLE;
      last_q    <= 1'b1;
      gnt_q     <= 1'b0;
      off_q     <= {`MMB_DN_AW{1'b0}};
      rd_q      <= 1'b0;
      wr_q      <= 1'b0;
      wdata_q   <= {`MMB_DW{1'b0}};
      hit_q     <= {`MMB_NUM_SLV{1'b0}};
      d_read_q  <= 1'b0;
      d_write_q <= 1'b0;
      d_sel_q   <= {`MMB_NUM_SLV{1'b0}};
      rdata_q   <= `MMB_RDATA_RST;
      ack0_q    <= 1'b0;
      ack1_q    <= 1'b0;
      miss0_q   <= 1'b0;
      miss1_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      ack0_q  <= 1'b0;
      ack1_q  <= 1'b0;
      miss0_q <= 1'b0;
      miss1_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (req0 | req1) begin
            gnt_q   <= pick;                                            // [R5]
            last_q  <= pick;
            off_q   <= sel_off;
            rd_q    <= sel_read;
            wr_q    <= sel_write;
            wdata_q <= sel_wdata;
            hit_q   <= hit_vec;
            if (!in_win || (hit_vec == {`MMB_NUM_SLV{1'b0}})) begin
              miss0_q <= ~pick;                                         // [R12]
              miss1_q <= pick;
            end else if (PIPE_M2S == 0) begin
              d_read_q  <= sel_read;
              d_write_q <= sel_write;
              d_sel_q   <= hit_vec & {`MMB_NUM_SLV{sel_read | sel_write}}; // [R7]
            end
          end
        end
        ST_STAGE: begin
          // extra register stage on the master-to-slave path
          d_read_q  <= rd_q;
          d_write_q <= wr_q;
          d_sel_q   <= hit_q & {`MMB_NUM_SLV{rd_q | wr_q}};             // [R7]
        end
        ST_XFER: begin
          if (dn_done) begin
            d_read_q  <= 1'b0;
            d_write_q <= 1'b0;
            d_sel_q   <= {`MMB_NUM_SLV{1'b0}};
            if (rd_q) begin
              rdata_q <= rd_mux;
            end
            if (PIPE_S2M == 0) begin
              ack0_q <= ~gnt_q;
              ack1_q <= gnt_q;
            end
          end
        end
        ST_RESP: begin
          // extra register stage on the slave-to-master path
          ack0_q <= ~gnt_q;                                             // [R11]
          ack1_q <= gnt_q;
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // outputs, all straight from flip-flops
  // ****************************************
  // address and write data fan out unmuxed to every slave
  assign d_addr   = off_q;                                              // [R9]
  assign d_wdata  = wdata_q;                                            // [R9]
  assign d_read   = d_read_q;
  assign d_write  = d_write_q;
  assign d_sel    = d_sel_q;
  assign m0_ack   = ack0_q;
  assign m1_ack   = ack1_q;
  assign m0_miss  = miss0_q;
  assign m1_miss  = miss1_q;
  assign m0_rdata = rdata_q;
  assign m1_rdata = rdata_q;

endmodule

`default_nettype wire

// ==== verif/mmb_bridge_checker.sv ====
// mmb_bridge_checker.sv: port checks on the bridge, bound in.
// assumes default pipelining and a single clock domain.
`timescale 1ns/10ps
`default_nettype none
`include "mmb_bridge_map.vh"
// ****
// checker
// ****
module mmb_bridge_checker (
  input wire                    ref_clk,
  input wire                    rst,
  input wire [`MMB_UP_AW-1:0]   m0_addr,
  input wire                    m0_ack,
  input wire                    m0_miss,
  input wire [`MMB_UP_AW-1:0]   m1_addr,
  input wire                    m1_ack,
  input wire [`MMB_DN_AW-1:0]   d_addr,
  input wire                    d_read,
  input wire                    d_write,
  input wire [`MMB_DW-1:0]      d_wdata,
  input wire [`MMB_NUM_SLV-1:0] d_sel,
  input wire [`MMB_NUM_SLV-1:0] d_wait
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // busy, done and window hit as seen at the ports
  wire dn_busy = d_read | d_write;
  wire dn_done = (|d_sel) && ((d_sel & d_wait) == 4'h0);
  wire m0_hit  = ((m0_addr & 16'hFF00) == `MMB_BRIDGE_BASE) && (m0_addr[7:4] != 4'h0);

  sel_onehot_a: assert property ($onehot0(d_sel))
    else $error("select not one-hot");
  sel_strobe_a: assert property ((|d_sel) == dn_busy)
    else $error("select and strobe disagree");
  sel_bit_a: assert property (|d_sel |-> d_sel == (d_addr[7:4] & (~d_addr[7:4] + 4'h1)))
    else $error("select not from offset bit");
  ack_excl_a: assert property (!(m0_ack && m1_ack))
    else $error("two acks at once");
  dn_hold_a: assert property (dn_busy && !dn_done |=> $stable(d_addr) && $stable(d_sel) && $stable(d_wdata))
    else $error("downstream changed while waiting");
  done_ack_a: assert property (dn_done |-> ##2 (m0_ack || m1_ack))
    else $error("ack not two cycles after completion");
  done_idle_a: assert property (dn_done |=> !dn_busy [*2])
    else $error("downstream not idle after completion");
  win_ack_a: assert property (m0_ack |-> m0_hit)
    else $error("ack outside window");
  win_miss_a: assert property (m0_miss |-> !m0_hit && !dn_busy)
    else $error("miss inside window");
  off_map_a: assert property ($rose(dn_busy) |-> d_addr == m0_addr[7:0] || d_addr == m1_addr[7:0])
    else $error("offset not from master address");
endmodule

bind mmb_bridge mmb_bridge_checker mmb_bridge_checker_i (.ref_clk, .rst, .m0_addr, .m0_ack,
  .m0_miss, .m1_addr, .m1_ack, .d_addr, .d_read, .d_write, .d_wdata, .d_sel, .d_wait);
`default_nettype wire

// ==== verif/mmb_slave_model.sv ====
// mmb_slave_model.sv: four slaves on the bridge's downstream side.
// assumes the bench sets wait_len; logs the last write and a count.
`timescale 1ns/10ps
`default_nettype none
module mmb_slave_model (
  input wire           ref_clk,
  input wire           rst,
  input wire [7:0]     d_addr,
  input wire           d_write,
  input wire [31:0]    d_wdata,
  input wire [3:0]     d_sel,
  input wire [3:0]     wait_len,
  output logic [3:0]   d_wait,
  output logic [127:0] d_rdata,
  output logic [7:0]   xfer_q,
  output logic [43:0]  wr_q
);
  logic [3:0]  cnt_q;
  logic [31:0] v;
  // idle slaves hold wait up and show inverted data, so stale reads show
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      d_wait[i] = !(d_sel[i] && cnt_q >= wait_len);
      v = {8'h5A, 6'h00, i[1:0], 8'h00, d_addr};
      d_rdata[i*32 +: 32] = d_wait[i] ? ~v : v;
    end
  end
  // stretch each access by wait_len cycles, then log it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 4'h0;
      xfer_q <= 8'h00;
      wr_q <= 44'h0;
    end else if (|(d_sel & ~d_wait)) begin
      cnt_q <= 4'h0;
      xfer_q <= xfer_q + 8'h01;
      if (d_write) begin
        wr_q <= {d_sel, d_addr, d_wdata};
      end
    end else if (|d_sel) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule
`default_nettype wire

// ==== verif/mmb_bridge_tb.sv ====
// mmb_bridge_tb.sv: self-checking bench for the two-master bridge.
// assumes the slave model downstream and default pipelining.
`timescale 1ns/10ps
`default_nettype none
`include "mmb_bridge_map.vh"
module mmb_bridge_tb;
  logic         ref_clk = 1'b0;
  logic         rst = 1'b1;
  logic [15:0]  addr [2] = '{16'h0, 16'h0};
  logic [31:0]  wdat [2] = '{32'h0, 32'h0};
  logic [1:0]   rd_r = 2'h0;
  logic [1:0]   wr_r = 2'h0;
  logic [3:0]   wait_len = 4'h0;
  wire [31:0]   rdat [2];
  wire [1:0]    ack;
  wire [1:0]    miss;
  wire [7:0]    d_addr;
  wire          d_read;
  wire          d_write;
  wire [31:0]   d_wdata;
  wire [3:0]    d_sel;
  wire [3:0]    d_wait;
  wire [127:0]  d_rdata;
  wire [7:0]    xfer_q;
  wire [43:0]   wr_q;
  int           errors = 0;
  int           comparisons = 0;

  mmb_bridge mmb_bridge_i (.ref_clk, .rst, .m0_addr(addr[0]), .m0_read(rd_r[0]),
    .m0_write(wr_r[0]), .m0_wdata(wdat[0]), .m0_ack(ack[0]), .m0_miss(miss[0]),
    .m0_rdata(rdat[0]), .m1_addr(addr[1]), .m1_read(rd_r[1]), .m1_write(wr_r[1]),
    .m1_wdata(wdat[1]), .m1_ack(ack[1]), .m1_miss(miss[1]), .m1_rdata(rdat[1]), .d_addr,
    .d_read, .d_write, .d_wdata, .d_sel, .d_wait, .d_rdata);
  mmb_slave_model slv_model (.ref_clk, .rst, .d_addr, .d_write, .d_wdata, .d_sel, .wait_len,
    .d_wait, .d_rdata, .xfer_q, .wr_q);

  always #25 ref_clk = ~ref_clk;

  // ****
  // shared tasks
  // ****
  task automatic chk(input string what, input logic [43:0] seen, input logic [43:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // request held until answer, dropped in the cycle after it
  task automatic xfer(input int m, input logic [15:0] a, input logic rd, input logic [31:0] wd,
                      output int lat, output logic ok, output logic [31:0] rv);
    @(posedge ref_clk);
    addr[m] <= a;
    rd_r[m] <= rd;
    wr_r[m] <= !rd;
    wdat[m] <= wd;
    lat = 0;
    do begin
      @(posedge ref_clk);
      #1;
      lat++;
    end while (ack[m] !== 1'b1 && miss[m] !== 1'b1 && lat < 40);
    ok = ack[m];
    rv = rdat[m];
    @(posedge ref_clk);
    rd_r[m] <= 1'b0;
    wr_r[m] <= 1'b0;
  endtask

  // ****
  // scenarios
  // ****
  task automatic t_reads;
    int lat; logic ok; logic [31:0] rv; logic [7:0] off;
    for (int i = 0; i < 4; i++) begin
      off = (8'h10 << i) | 8'h0C;
      xfer(0, `MMB_BRIDGE_BASE + {8'h00, off}, 1'b1, 32'h0, lat, ok, rv);
      chk("read ack", ok, 1);
      chk("read latency", lat, 4);
      chk("read data", rv, {8'h5A, 6'h00, i[1:0], 8'h00, off});
    end
  endtask

  // slow slave stretches a write; the bridge must hold and log it whole
  task automatic t_write;
    int lat; logic ok; logic [31:0] rv;
    @(posedge ref_clk);
    wait_len <= 4'h3;
    xfer(1, 16'h1084, 1'b0, 32'hCAFE0001, lat, ok, rv);
    chk("write ack", ok, 1);
    chk("write stretched", lat > 4, 1);
    chk("write logged", wr_q, {4'h8, 8'h84, 32'hCAFE0001});
    wait_len <= 4'h0;
  endtask

  task automatic t_miss;
    logic [15:0] bad [4] = '{16'h2010, 16'h0FF0, 16'h1100, 16'h1008};
    int lat; logic ok; logic [31:0] rv; logic [7:0] n;
    for (int i = 0; i < 4; i++) begin
      n = xfer_q;
      xfer(i % 2, bad[i], 1'b0, 32'hDEADBEEF, lat, ok, rv);
      chk("miss answer", ok, 0);
      chk("miss latency", lat, 1);
      chk("quiet downstream", xfer_q, n);
    end
  endtask

  // both masters at once: one waits for the other
  task automatic t_arb;
    int la, lb; logic oa, ob; logic [31:0] ra, rb;
    fork
      xfer(0, 16'h1014, 1'b1, 32'h0, la, oa, ra);
      xfer(1, 16'h1024, 1'b1, 32'h0, lb, ob, rb);
    join
    chk("arb acks", {oa, ob}, 2'h3);
    chk("arb serial", la != lb, 1);
    chk("arb data 0", ra, 32'h5A000014);
    chk("arb data 1", rb, 32'h5A010024);
  endtask

  task automatic end_of_test;
    if (errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    t_reads();
    t_write();
    t_miss();
    t_arb();
    end_of_test();
  end

  // the scenarios need about 60 cycles; this cuts a hang short
  initial begin
    repeat (3000) @(posedge ref_clk);
    errors++;
    end_of_test();
  end
endmodule
`default_nettype wire
